/* inc/csp_pkg.sv */
// Shared constants and types for the host serial port
package csp_pkg;

   // ==========================================================================
   // Slave addressing
   localparam logic [7:0]  CSP_BASE_SEL0   = 8'h78;
   localparam logic [7:0]  CSP_BASE_SEL1   = 8'h7A;

   // ==========================================================================
   // Register space and indirect memory window
   localparam logic [15:0] CSP_ADDR_STEP   = 16'h0002;
   localparam logic [15:0] CSP_OFS_WIN_ADDR = 16'h098C;
   localparam logic [15:0] CSP_OFS_WIN_DATA = 16'h0990;
   localparam int          CSP_WIN_ID_LSB  = 8;
   localparam logic [15:0] CSP_WIN_RESET   = 16'h0000;
   localparam logic [15:0] CSP_UNKNOWN_RD  = 16'h0000;

   // ==========================================================================
   // Firmware driver identifiers
   localparam logic [4:0]  CSP_DRV_SEQ     = 5'h01;
   localparam logic [4:0]  CSP_DRV_AE      = 5'h02;
   localparam logic [4:0]  CSP_DRV_AWB     = 5'h03;
   localparam logic [4:0]  CSP_DRV_FLICKER = 5'h04;
   localparam logic [4:0]  CSP_DRV_CONTEXT = 5'h07;
   localparam logic [4:0]  CSP_DRV_HIST    = 5'h0B;

   // ==========================================================================
   // Serial framing
   localparam logic [3:0]  CSP_LAST_BIT    = 4'h7;

   typedef enum logic [2:0] {
      CSP_IDLE, CSP_RX, CSP_ACK1, CSP_ACK2, CSP_TX, CSP_RACK, CSP_TXLD
   } csp_state_e;

   typedef enum logic [2:0] {
      CSP_PH_DEV, CSP_PH_AHI, CSP_PH_ALO, CSP_PH_DHI, CSP_PH_DLO, CSP_PH_RHI, CSP_PH_RLO
   } csp_phase_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        logical;
      logic [15:0] addr;
      logic [15:0] wdata;
   } csp_req_s;

   typedef struct packed {
      csp_state_e  state;
      csp_phase_e  phase;
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_q;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_q;
      logic        sel_s1;
      logic        sel_s2;
      logic        stb_s1;
      logic        stb_s2;
      logic        core_on;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic        sda_oe;
      logic [15:0] addr;
      logic [7:0]  wdata_hi;
      logic [15:0] txword;
      logic [15:0] win_addr;
      csp_req_s    hreq;
      csp_req_s    bus;
      logic        bus_host;
      logic        cap_host;
      logic        cap_mcu;
      logic        mcu_gnt;
      logic        mcu_rvalid;
      logic [15:0] mcu_rdata;
   } csp_st_s;

   localparam csp_st_s CSP_ST_RESET = '0;

   function automatic logic csp_drv_known(input logic [4:0] id);
      return id inside {CSP_DRV_SEQ, CSP_DRV_AE, CSP_DRV_AWB, CSP_DRV_FLICKER,
                        CSP_DRV_CONTEXT, CSP_DRV_HIST};
   endfunction

endpackage

/* logic/csp_host_port.sv */
// Two-wire slave host port with register access and host-first arbitration
`timescale 1ns/1ps

// Overview of operation
// - Slave only; never drives clock or starts
// - Address 0x78 select low, 0x7A high
// - 32K sixteen-bit registers at even addresses
// - Host reads and writes registers directly
// - Window registers reach memory by logical address
// - Data line only pulled low or released
// - Port stays working through standby
// - Clock, reset, configuration stay reachable in standby
// - Patch memory stays powered during standby
// - Driver space organised by driver identifier
// - Host wins contention with the microcontroller
module csp_host_port (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Two-wire pins
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   input  wire logic              addr_sel_i,
   // Power control
   input  wire logic              standby_i,
   output logic                   core_on_o,
   output logic                   patch_pwr_o,
   // Internal register and memory space
   output csp_pkg::csp_req_s      reg_req_o,
   input  wire logic [15:0]       reg_rdata_i,
   // Microcontroller access
   input  csp_pkg::csp_req_s      mcu_req_i,
   output logic                   mcu_gnt_o,
   output logic                   mcu_rvalid_o,
   output logic [15:0]            mcu_rdata_o
);

   // ==========================================================================
   // Reset release
   logic [1:0]          rst_q;
   logic                rst_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ==========================================================================
   // State
   csp_pkg::csp_st_s    s;
   csp_pkg::csp_st_s    n;
   logic                scl_rise;
   logic                scl_fall;
   logic                start_det;
   logic                stop_det;
   logic [7:0]          rx_byte;
   logic [7:0]          my_base;
   logic                do_wr;
   logic                do_rd;
   logic [15:0]         req_addr;
   logic [7:0]          tx_byte;
   csp_pkg::csp_req_s   tgt;

   // Only synchronised copies are looked at, so glitches near the edge are harmless
   assign scl_rise  = s.scl_s2 & ~s.scl_q;
   assign scl_fall  = ~s.scl_s2 & s.scl_q;
   assign start_det = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
   assign stop_det  = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
   assign rx_byte   = {s.shreg[6:0], s.sda_s2};
   assign my_base   = s.sel_s2 ? csp_pkg::CSP_BASE_SEL1 : csp_pkg::CSP_BASE_SEL0;

   always_comb begin
      n        = s;
      do_wr    = 1'b0;
      do_rd    = 1'b0;
      req_addr = s.addr;
      tx_byte  = (s.phase == csp_pkg::CSP_PH_RHI) ? s.txword[15:8] : s.txword[7:0];
      tgt      = '0;
      n.scl_s1 = scl_i;
      n.scl_s2 = s.scl_s1;
      n.scl_q  = s.scl_s2;
      n.sda_s1 = sda_i;
      n.sda_s2 = s.sda_s1;
      n.sda_q  = s.sda_s2;
      n.sel_s1 = addr_sel_i;
      n.sel_s2 = s.sel_s1;
      n.stb_s1 = standby_i;
      n.stb_s2 = s.stb_s1;
      n.core_on = ~s.stb_s2;

      // Read data returns one cycle after the request is on the bus
      n.bus.valid  = 1'b0;
      n.mcu_gnt    = 1'b0;
      n.mcu_rvalid = 1'b0;
      n.cap_host   = s.bus.valid & ~s.bus.write & s.bus_host;
      n.cap_mcu    = s.bus.valid & ~s.bus.write & ~s.bus_host;
      if (s.cap_host) begin
         n.txword = reg_rdata_i;
      end
      if (s.cap_mcu) begin
         n.mcu_rdata  = reg_rdata_i;
         n.mcu_rvalid = 1'b1;
      end

      // Host request always goes first; the core is served only while powered
      if (s.hreq.valid) begin
         n.bus        = s.hreq;
         n.bus_host   = 1'b1;
         n.hreq.valid = 1'b0;
      end else if (mcu_req_i.valid && s.core_on && !s.stb_s2) begin
         n.bus         = mcu_req_i;
         n.bus.logical = 1'b0;
         n.bus_host    = 1'b0;
         n.mcu_gnt     = 1'b1;
      end

      // ========================================================================
      // Serial protocol, timed only by the host's clock edges
      if (start_det) begin
         n.state  = csp_pkg::CSP_RX;
         n.phase  = csp_pkg::CSP_PH_DEV;
         n.bitcnt = '0;
         n.sda_oe = 1'b0;
      end else if (stop_det) begin
         n.state  = csp_pkg::CSP_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         case (s.state)
            csp_pkg::CSP_RX: begin
               if (scl_rise) begin
                  n.shreg  = rx_byte;
                  n.bitcnt = 4'(s.bitcnt + 4'h1);
                  if (s.bitcnt == csp_pkg::CSP_LAST_BIT) begin
                     n.state = csp_pkg::CSP_ACK1;
                     case (s.phase)
                        csp_pkg::CSP_PH_DEV: begin
                           if (rx_byte[7:1] == my_base[7:1]) begin
                              if (rx_byte[0]) begin
                                 n.phase = csp_pkg::CSP_PH_RHI;
                                 do_rd   = 1'b1;
                              end else begin
                                 n.phase = csp_pkg::CSP_PH_AHI;
                              end
                           end else begin
                              n.state = csp_pkg::CSP_IDLE;
                           end
                        end
                        csp_pkg::CSP_PH_AHI: begin
                           n.addr[15:8] = rx_byte;
                           n.phase      = csp_pkg::CSP_PH_ALO;
                        end
                        csp_pkg::CSP_PH_ALO: begin
                           n.addr[7:0] = rx_byte;
                           n.phase     = csp_pkg::CSP_PH_DHI;
                        end
                        csp_pkg::CSP_PH_DHI: begin
                           n.wdata_hi = rx_byte;
                           n.phase    = csp_pkg::CSP_PH_DLO;
                        end
                        default: begin
                           do_wr   = 1'b1;
                           n.addr  = s.addr + csp_pkg::CSP_ADDR_STEP;
                           n.phase = csp_pkg::CSP_PH_DHI;
                        end
                     endcase
                  end
               end
            end
            csp_pkg::CSP_ACK1: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b1;
                  n.state  = csp_pkg::CSP_ACK2;
               end
            end
            csp_pkg::CSP_ACK2: begin
               if (scl_fall) begin
                  n.bitcnt = '0;
                  if (s.phase == csp_pkg::CSP_PH_RHI) begin
                     n.shreg  = tx_byte;
                     n.sda_oe = ~tx_byte[7];
                     n.state  = csp_pkg::CSP_TX;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.state  = csp_pkg::CSP_RX;
                  end
               end
            end
            csp_pkg::CSP_TX: begin
               if (scl_fall) begin
                  if (s.bitcnt == csp_pkg::CSP_LAST_BIT) begin
                     n.sda_oe = 1'b0;
                     n.bitcnt = '0;
                     n.state  = csp_pkg::CSP_RACK;
                  end else begin
                     n.bitcnt = 4'(s.bitcnt + 4'h1);
                     n.shreg  = {s.shreg[6:0], 1'b0};
                     n.sda_oe = ~s.shreg[6];
                  end
               end
            end
            csp_pkg::CSP_RACK: begin
               if (scl_rise) begin
                  if (s.sda_s2) begin
                     n.state = csp_pkg::CSP_IDLE;
                  end else if (s.phase == csp_pkg::CSP_PH_RHI) begin
                     n.phase = csp_pkg::CSP_PH_RLO;
                     n.state = csp_pkg::CSP_TXLD;
                  end else begin
                     n.addr   = s.addr + csp_pkg::CSP_ADDR_STEP;
                     req_addr = n.addr;
                     do_rd    = 1'b1;
                     n.phase  = csp_pkg::CSP_PH_RHI;
                     n.state  = csp_pkg::CSP_TXLD;
                  end
               end
            end
            csp_pkg::CSP_TXLD: begin
               if (scl_fall) begin
                  n.shreg  = tx_byte;
                  n.sda_oe = ~tx_byte[7];
                  n.state  = csp_pkg::CSP_TX;
               end
            end
            default: begin
               n.sda_oe = 1'b0;
            end
         endcase
      end

      // ========================================================================
      // Request issue; the window address register and unknown-driver window data are served here, the rest go out
      if (do_wr || do_rd) begin
         tgt.valid = 1'b1;
         tgt.write = do_wr;
         tgt.wdata = {s.wdata_hi, rx_byte};
         tgt.addr  = {req_addr[15:1], 1'b0};
         if (tgt.addr == csp_pkg::CSP_OFS_WIN_ADDR) begin
            if (do_wr) begin
               n.win_addr = tgt.wdata;
            end else begin
               n.txword = s.win_addr;
            end
         end else if (tgt.addr == csp_pkg::CSP_OFS_WIN_DATA) begin
            if (csp_pkg::csp_drv_known(s.win_addr[csp_pkg::CSP_WIN_ID_LSB +: 5])) begin
               tgt.logical = 1'b1;
               tgt.addr    = s.win_addr;
               n.win_addr  = s.win_addr + csp_pkg::CSP_ADDR_STEP;
               n.hreq      = tgt;
            end else if (do_rd) begin
               n.txword = csp_pkg::CSP_UNKNOWN_RD;
            end
         end else begin
            n.hreq = tgt;
         end
      end
   end

   // Reset of the port alone; standby never resets this state, it only drops core_on and holds off microcontroller grants
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s <= csp_pkg::CSP_ST_RESET;
      end else begin
         s <= n;
      end
   end

   // ==========================================================================
   // Outputs
   assign sda_o        = 1'b0;
   assign sda_oe_o     = s.sda_oe;
   assign core_on_o    = s.core_on;
   assign patch_pwr_o  = 1'b1;
   assign reg_req_o    = s.bus;
   assign mcu_gnt_o    = s.mcu_gnt;
   assign mcu_rvalid_o = s.mcu_rvalid;
   assign mcu_rdata_o  = s.mcu_rdata;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_dev_byte;
      s.state == csp_pkg::CSP_RX && s.phase == csp_pkg::CSP_PH_DEV && scl_rise
      && s.bitcnt == csp_pkg::CSP_LAST_BIT && !start_det && !stop_det;
   endsequence

   property p_drive_only_when_owner;
      sda_oe_o |-> (s.state inside {csp_pkg::CSP_ACK2, csp_pkg::CSP_TX});
   endproperty
   a_drive_only_when_owner: assert property (p_drive_only_when_owner)
      else $error("data line driven outside ack or read phase");

   property p_addr_match;
      s_dev_byte and (rx_byte[7:1] == my_base[7:1]) |=> s.state == csp_pkg::CSP_ACK1;
   endproperty
   a_addr_match: assert property (p_addr_match)
      else $error("own address not acknowledged");

   property p_addr_miss;
      s_dev_byte and (rx_byte[7:1] != my_base[7:1]) |=> s.state == csp_pkg::CSP_IDLE;
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("foreign address answered");

   property p_even_addr;
      reg_req_o.valid && !reg_req_o.logical |-> reg_req_o.addr[0] == 1'b0;
   endproperty
   a_even_addr: assert property (p_even_addr)
      else $error("odd register address issued");

   property p_host_first;
      s.hreq.valid && mcu_req_i.valid |=> reg_req_o.valid && s.bus_host && !mcu_gnt_o;
   endproperty
   a_host_first: assert property (p_host_first)
      else $error("microcontroller granted over host");

   property p_standby_host;
      s.stb_s2 && s.hreq.valid |=> reg_req_o.valid ##1 !mcu_gnt_o;
   endproperty
   a_standby_host: assert property (p_standby_host)
      else $error("host access lost in standby");

   property p_standby_core;
      s.stb_s2 |=> !core_on_o && !mcu_gnt_o;
   endproperty
   a_standby_core: assert property (p_standby_core)
      else $error("core left on in standby");

   property p_oe_on_fall;
      $changed(s.sda_oe) |-> !s.scl_q || $past(stop_det) || $past(start_det);
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall)
      else $error("data line changed while clock high");

   property p_write_word;
      s.state == csp_pkg::CSP_RX && s.phase == csp_pkg::CSP_PH_DLO && scl_rise
      && s.bitcnt == csp_pkg::CSP_LAST_BIT && !start_det && !stop_det
      |=> s.addr == $past(s.addr) + csp_pkg::CSP_ADDR_STEP;
   endproperty
   a_write_word: assert property (p_write_word)
      else $error("address not stepped after data word");

endmodule

/* bench/csp_host_master.sv */
// Behavioural two-wire bus master standing in for the host controller
`timescale 1ns/1ps

module csp_host_master #(
   parameter realtime T_Q = 31.25 // Quarter bit; faster than in-system rate for short runs
) (
   // Bus lines
   output logic      scl_o,
   output logic      sda_pull_o,
   input  wire logic sda_i
);
   // ==========================================================================
   // Clock stands still, both lines released, between frames
   initial begin
      scl_o      = 1'b1;
      sda_pull_o = 1'b0;
   end

   // ==========================================================================
   // Bus conditions; start also serves as repeated start
   task automatic start();
      sda_pull_o = 1'b0;
      #(T_Q);
      scl_o = 1'b1;
      #(T_Q);
      sda_pull_o = 1'b1;
      #(T_Q);
      scl_o = 1'b0;
      #(T_Q);
   endtask

   task automatic stop();
      sda_pull_o = 1'b1;
      #(T_Q);
      scl_o = 1'b1;
      #(T_Q);
      sda_pull_o = 1'b0;
      #(2 * T_Q);
   endtask

   // Data moves only while the clock is low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      sda_pull_o = ~b;
      #(T_Q);
      scl_o = 1'b1;
      #(T_Q);
      s = sda_i;
      #(T_Q);
      scl_o = 1'b0;
      #(T_Q);
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(nack, s);
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the host serial port
`timescale 1ns/1ps

module testbench;
   logic clk_i, rst_n_i, addr_sel_i, standby_i, sda_o, sda_oe_o, scl, pull;
   logic core_on_o, patch_pwr_o, mcu_gnt_o, mcu_rvalid_o;
   logic [15:0] reg_rdata_i, mcu_rdata_o;
   csp_pkg::csp_req_s reg_req_o, mcu_req_i;
   csp_pkg::csp_req_s wr_q[$];
   int mismatches = 0, num_checks = 0, cyc = 0, gnt_cnt = 0;
   wire sda = ~(pull | sda_oe_o);

   csp_host_master host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));

   csp_host_port dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .standby_i(standby_i),
      .core_on_o(core_on_o), .patch_pwr_o(patch_pwr_o), .reg_req_o(reg_req_o),
      .reg_rdata_i(reg_rdata_i), .mcu_req_i(mcu_req_i), .mcu_gnt_o(mcu_gnt_o),
      .mcu_rvalid_o(mcu_rvalid_o), .mcu_rdata_o(mcu_rdata_o));

   // ==========================================================================
   // Clock, internal space stand-in, timeout
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc++;
      if (reg_req_o.valid && !reg_req_o.write) reg_rdata_i <= #1 reg_req_o.addr ^ 16'hC35A;
      if (reg_req_o.valid && reg_req_o.write && !mcu_gnt_o) wr_q.push_back(reg_req_o);
      if (mcu_gnt_o) gnt_cnt++;
      if (cyc == 60000) begin
         mismatches++;
         final_report();
      end
   end

   // ==========================================================================
   // Shared helpers
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cycles(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   function automatic logic [7:0] dev();
      return addr_sel_i ? csp_pkg::CSP_BASE_SEL1 : csp_pkg::CSP_BASE_SEL0;
   endfunction

   task automatic hwr(logic [7:0] d, logic [15:0] a, logic [15:0] w0, logic [15:0] w1,
                      bit two, output int acks);
      logic [7:0] b[$];
      logic k;
      b = {d, a[15:8], a[7:0], w0[15:8], w0[7:0]};
      if (two) b = {b, w1[15:8], w1[7:0]};
      acks = 0;
      host.start();
      foreach (b[i]) begin
         host.wbyte(b[i], k);
         acks += int'(k);
      end
      host.stop();
      cycles(4);
   endtask

   task automatic hrd(logic [15:0] a, output logic [15:0] r0, output logic [15:0] r1);
      logic k;
      host.start();
      host.wbyte(dev(), k);
      host.wbyte(a[15:8], k);
      host.wbyte(a[7:0], k);
      host.start();
      host.wbyte(dev() | 8'h01, k);
      host.rbyte(1'b0, r0[15:8]);
      host.rbyte(1'b0, r0[7:0]);
      host.rbyte(1'b0, r1[15:8]);
      host.rbyte(1'b1, r1[7:0]);
      host.stop();
      cycles(4);
   endtask

   task automatic chk_wr(logic [15:0] a, logic [15:0] d, logic lg);
      csp_pkg::csp_req_s r;
      check("write count", 32'(wr_q.size() > 0), 32'h1);
      if (wr_q.size() > 0) begin
         r = wr_q.pop_front();
         check("write addr", {16'h0, r.addr}, {16'h0, a});
         check("write data", {16'h0, r.wdata}, {16'h0, d});
         check("write logical", {31'h0, r.logical}, {31'h0, lg});
      end
   endtask

   // ==========================================================================
   // Scenarios
   task automatic sc_addr_sel();
      int n;
      for (int s = 0; s < 2; s++) begin
         addr_sel_i = s[0];
         cycles(10);
         hwr(dev(), 16'h0040, 16'h1111, 16'h0, 0, n);
         check("own addr acks", n, 5);
         chk_wr(16'h0040, 16'h1111, 1'b0);
         hwr(dev() ^ 8'h02, 16'h0040, 16'h2222, 16'h0, 0, n);
         check("other addr acks", n, 0);
         check("other addr writes", wr_q.size(), 0);
      end
      addr_sel_i = 1'b0;
      cycles(10);
   endtask

   task automatic sc_write_pair();
      int n;
      hwr(dev(), 16'h1235, 16'hBEEF, 16'h0A5C, 1, n);
      check("pair acks", n, 7);
      chk_wr(16'h1234, 16'hBEEF, 1'b0);
      chk_wr(16'h1236, 16'h0A5C, 1'b0);
      check("line released", {sda_oe_o, sda_o}, 2'b00);
   endtask

   task automatic sc_read();
      logic [15:0] r0, r1;
      hrd(16'h2000, r0, r1);
      check("read word 0", r0, 16'h2000 ^ 16'hC35A);
      check("read word 1", r1, 16'h2002 ^ 16'hC35A);
   endtask

   task automatic sc_window();
      logic [4:0] ids[7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h0B, 5'h05};
      logic [15:0] wa, r0, r1, ex;
      int n;
      foreach (ids[i]) begin
         wa = 16'(ids[i]) << csp_pkg::CSP_WIN_ID_LSB | 16'h0040;
         hwr(dev(), csp_pkg::CSP_OFS_WIN_ADDR, wa, 16'h0, 0, n);
         if (i == 0) begin
            hrd(csp_pkg::CSP_OFS_WIN_ADDR, r0, r1);
            check("window addr readback", r0, wa);
         end
         hwr(dev(), csp_pkg::CSP_OFS_WIN_DATA, 16'h5A00 | 16'(i), 16'h0, 0, n);
         if (i < 6) chk_wr(wa, 16'h5A00 | 16'(i), 1'b1);
         else check("unknown driver dropped", wr_q.size(), 0);
         if (i == 0 || i == 6) begin
            hrd(csp_pkg::CSP_OFS_WIN_DATA, r0, r1);
            ex = (i == 0) ? (wa + csp_pkg::CSP_ADDR_STEP) ^ 16'hC35A : csp_pkg::CSP_UNKNOWN_RD;
            check("window data read", r0, ex);
         end
      end
   endtask

   task automatic sc_mcu_contend();
      int n;
      mcu_req_i = '{valid: 1'b1, write: 1'b0, logical: 1'b0, addr: 16'h3000, wdata: 16'h0};
      hwr(dev(), 16'h0300, 16'h7E7E, 16'h0, 0, n);
      chk_wr(16'h0300, 16'h7E7E, 1'b0);
      check("mcu served meanwhile", 32'(gnt_cnt > 0), 32'h1);
      mcu_req_i.valid = 1'b0;
      cycles(4);
      mcu_req_i.valid = 1'b1;
      n = 0;
      while (mcu_gnt_o !== 1'b1 && n < 20) begin
         cycles(1);
         n++;
      end
      check("mcu grant", mcu_gnt_o, 1'b1);
      check("mcu addr", reg_req_o.addr, 16'h3000);
      mcu_req_i.valid = 1'b0;
      cycles(2);
      check("mcu rvalid", mcu_rvalid_o, 1'b1);
      check("mcu rdata", mcu_rdata_o, 16'h3000 ^ 16'hC35A);
   endtask

   task automatic sc_standby();
      int n, g0;
      mcu_req_i.valid = 1'b1;
      standby_i = 1'b1;
      cycles(10);
      check("core off", core_on_o, 1'b0);
      check("patch power", patch_pwr_o, 1'b1);
      g0 = gnt_cnt;
      hwr(dev(), 16'h0014, 16'h25F9, 16'h0, 0, n);
      check("standby acks", n, 5);
      chk_wr(16'h0014, 16'h25F9, 1'b0);
      check("mcu held off", gnt_cnt - g0, 0);
      mcu_req_i.valid = 1'b0;
      standby_i = 1'b0;
      cycles(10);
      check("core on", core_on_o, 1'b1);
   endtask

   // ==========================================================================
   // Closing and main sequence
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      rst_n_i = 1'b0;
      addr_sel_i = 1'b0;
      standby_i = 1'b0;
      reg_rdata_i = 16'h0;
      mcu_req_i = '0;
      cycles(10);
      rst_n_i = 1'b1;
      cycles(10);
      sc_addr_sel();
      sc_write_pair();
      sc_read();
      sc_window();
      sc_mcu_contend();
      sc_standby();
      final_report();
   end
endmodule
